//--- scs_spi_port.sv
// Purpose: Clock-stop SPI-compatible serial port, inverted clock polarity
// Assumes: AXI4-Lite slave, one outstanding read and one write
// Notes:   All pins pass two flops before use
// Behaviour
// [RL1] 10b master: data after falls, first fall H after select, select held T after.
// [RL2] 11b master: data after rises, first fall T after select, select held H.
// [RL3] Receive data is sampled on serial clock rising edges, all modes and roles.
// [RL4] Master releases data H after last rise (10b) or at it (11b).
// [RL5] Slave releases data output when select input returns high.
// [RL6] Slave shows first bit on select low; 11b master L after select.
// [RL7] Bit clock period is divider plus one input clock periods.
// [RL8] Even divider: high div/2+1, low div/2; odd: both (div+1)/2.
// [RL9] Divider input is CPU clock over two, or the external clock pin.
// [RL10] Master: transmit clock and select directions 1, receive directions 0.
// [RL11] Slave: all four direction bits are 0, clock and select come in.
// [RL12] Slave modes run the divider at half CPU clock, divider value 1; the code leaves CB_SRC and the divider register as written.
// [RL13] Select polarity 1 makes the master select pin active low.
// [RL14] Slave inverts the active-low select inputs before internal use.
// [RL15] Select goes low before the first rising edge of the transfer.
// [RL16] Word length setting gives bit count and select length in clocks.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
module scs_spi_port
  import scs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  input  wire logic        ext_clock_pin,
  input  wire logic        tx_serial_clock_pin_i,
  output logic             tx_serial_clock_pin_o,
  output logic             tx_serial_clock_pin_oe,
  input  wire logic        tx_select_pin_i,
  output logic             tx_select_pin_o,
  output logic             tx_select_pin_oe,
  input  wire logic        rx_select_pin_i,
  input  wire logic        rx_data_pin,
  output logic             tx_data_pin_o,
  output logic             tx_data_pin_oe
);
  // ----------------------------------------
  // Pin synchronisers and bit clock
  // ----------------------------------------
  logic [4:0] sy;
  logic       sy_ext, sy_clk, sy_txs, sy_rxs, sy_rx;
  scs_srg_if  srg ();

  scs_sync2 #(.W(5)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({ext_clock_pin, tx_serial_clock_pin_i, tx_select_pin_i, rx_select_pin_i, rx_data_pin}),
    .q    (sy)
  );
  assign {sy_ext, sy_clk, sy_txs, sy_rxs, sy_rx} = sy;

  scs_bit_clock_gen u_gen (
    .mclk (mclk),
    .rst  (rst),
    .srg  (srg)
  );

  // ----------------------------------------
  // Register bus state
  // ----------------------------------------
  logic [31:0] ctrl_reg, ctrl_next;
  logic [7:0]  div_reg, div_next;
  logic [4:0]  wlen_reg, wlen_next;
  logic [31:0] txd_reg, txd_next;
  logic        done_reg, done_next;
  logic        start_reg, start_next;
  logic        awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
  logic        arr_reg, arr_next, rv_reg, rv_next;
  logic [1:0]  br_reg, br_next, rr_reg, rr_next;
  logic [31:0] rd_reg, rd_next, wd_reg, wd_next, wm;
  logic [7:0]  wa_reg, wa_next;
  logic [3:0]  ws_reg, ws_next;
  // Engine state
  scs_state_e  st_reg, st_next;
  logic [31:0] tsh_reg, tsh_next, rsh_reg, rsh_next, rxd_reg, rxd_next;
  logic [5:0]  cnt_reg, cnt_next, bits;
  logic        sck_reg, sck_next, sel_reg, sel_next, dx_reg, dx_next, oe_reg, oe_next;
  logic        run_reg, run_next, dp_reg, dp_next;
  logic        ck_q_reg, sl_q_reg, ex_q_reg, tk_reg;
  logic        mst, slv, is_b, s_act, s_rise, s_fall, last;
  logic [1:0]  var_sel;

  assign var_sel = ctrl_reg[CB_VAR+1:CB_VAR];
  assign is_b    = (var_sel == VAR_B);
  assign bits    = {1'b0, wlen_reg} + 6'd1; // RL16
  assign mst = ctrl_reg[CB_TXCKDIR] & ctrl_reg[CB_TXSLDIR] & ~ctrl_reg[CB_RXCKDIR] & ~ctrl_reg[CB_RXSLDIR]; // RL10
  assign slv = ~(ctrl_reg[CB_TXCKDIR] | ctrl_reg[CB_TXSLDIR] | ctrl_reg[CB_RXCKDIR] | ctrl_reg[CB_RXSLDIR]); // RL11
  // Either select input may carry the enable
  assign s_act  = (sy_txs ^ ctrl_reg[CB_TXSLPOL]) | (sy_rxs ^ ctrl_reg[CB_RXSLPOL]); // RL14
  assign s_rise = sy_clk & ~ck_q_reg;
  assign s_fall = ~sy_clk & ck_q_reg;
  assign last   = (cnt_reg + 6'd1 == bits);
  assign wm     = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};

  assign srg.run       = run_reg;
  assign srg.start_low = is_b;
  assign srg.src_sel   = ctrl_reg[CB_SRC]; // RL12
  assign srg.div       = div_reg;
  assign srg.ext_tick  = tk_reg;

  // ----------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------
  always_comb begin
    ctrl_next  = ctrl_reg;
    div_next   = div_reg;
    wlen_next  = wlen_reg;
    txd_next   = txd_reg;
    start_next = 1'b0;
    // Hardware set wins over a same-cycle software clear
    done_next  = done_reg;
    awr_next = awr_reg; wr_next = wr_reg; bv_next = bv_reg; br_next = br_reg;
    arr_next = arr_reg; rv_next = rv_reg; rr_next = rr_reg; rd_next = rd_reg;
    wa_next  = wa_reg;  wd_next = wd_reg; ws_next = ws_reg;
    if (s_axi_awvalid && awr_reg) begin
      wa_next  = s_axi_awaddr;
      awr_next = 1'b0;
    end
    if (s_axi_wvalid && wr_reg) begin
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
      wr_next = 1'b0;
    end
    if (!awr_reg && !wr_reg && !bv_reg) begin
      bv_next = 1'b1;
      br_next = RESP_OK;
      case ({wa_reg[7:2], 2'b00})
        OFF_CTRL: begin
          ctrl_next  = (ctrl_reg & ~wm) | (wd_reg & wm);
          ctrl_next[CB_START] = 1'b0;
          start_next = ws_reg[0] & wd_reg[CB_START];
        end
        OFF_DIV:    if (ws_reg[0]) div_next = wd_reg[7:0];
        OFF_WLEN:   if (ws_reg[0]) wlen_next = wd_reg[4:0];
        OFF_TXDATA: txd_next = (txd_reg & ~wm) | (wd_reg & wm);
        OFF_STATUS: if (ws_reg[0] && wd_reg[SB_DONE]) done_next = 1'b0;
        OFF_RXDATA: br_next = RESP_OK;
        default:    br_next = RESP_ERR;
      endcase
    end
    if (bv_reg && s_axi_bready) begin
      bv_next  = 1'b0;
      awr_next = 1'b1;
      wr_next  = 1'b1;
    end
    if (s_axi_arvalid && arr_reg) begin
      arr_next = 1'b0;
      rv_next  = 1'b1;
      rr_next  = RESP_OK;
      case ({s_axi_araddr[7:2], 2'b00})
        OFF_CTRL:   rd_next = ctrl_reg;
        OFF_DIV:    rd_next = {24'h000000, div_reg};
        OFF_WLEN:   rd_next = {27'h0000000, wlen_reg};
        OFF_TXDATA: rd_next = txd_reg;
        OFF_RXDATA: rd_next = rxd_reg;
        OFF_STATUS: rd_next = {30'h00000000, done_reg, st_reg != ST_IDLE};
        default: begin
          rd_next = 32'h00000000;
          rr_next = RESP_ERR;
        end
      endcase
    end
    if (rv_reg && s_axi_rready) begin
      rv_next  = 1'b0;
      arr_next = 1'b1;
    end
    if (dp_reg) done_next = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_reg <= RST_CTRL; div_reg <= RST_DIV; wlen_reg <= RST_WLEN;
      txd_reg  <= 32'h00000000; done_reg <= 1'b0; start_reg <= 1'b0;
      awr_reg  <= 1'b1; wr_reg <= 1'b1; bv_reg <= 1'b0; br_reg <= RESP_OK;
      arr_reg  <= 1'b1; rv_reg <= 1'b0; rr_reg <= RESP_OK; rd_reg <= 32'h00000000;
      wa_reg   <= 8'h00; wd_reg <= 32'h00000000; ws_reg <= 4'h0;
    end else begin
      ctrl_reg <= ctrl_next; div_reg <= div_next; wlen_reg <= wlen_next;
      txd_reg  <= txd_next; done_reg <= done_next; start_reg <= start_next;
      awr_reg  <= awr_next; wr_reg <= wr_next; bv_reg <= bv_next; br_reg <= br_next;
      arr_reg  <= arr_next; rv_reg <= rv_next; rr_reg <= rr_next; rd_reg <= rd_next;
      wa_reg   <= wa_next; wd_reg <= wd_next; ws_reg <= ws_next;
    end
  end

  // ----------------------------------------
  // Transfer engine
  // ----------------------------------------
  always_comb begin
    st_next  = st_reg;  tsh_next = tsh_reg; rsh_next = rsh_reg; rxd_next = rxd_reg;
    cnt_next = cnt_reg; sck_next = sck_reg; sel_next = sel_reg;
    dx_next  = dx_reg;  oe_next  = oe_reg;  dp_next  = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        sck_next = 1'b1;
        sel_next = 1'b0;
        cnt_next = 6'd0;
        tsh_next = txd_reg << (5'd31 - wlen_reg);
        if (start_reg && mst) begin
          sel_next = 1'b1; // RL15
          st_next  = is_b ? ST_LEAD : ST_SHIFT;
        end else if (slv && s_act) begin
          // First bit goes out on select alone, no clock edge needed
          dx_next  = tsh_next[31]; // RL6
          oe_next  = 1'b1;
          tsh_next = tsh_next << 1;
          st_next  = ST_SLAVE;
        end
      end
      ST_LEAD: if (srg.rise_p) begin
        dx_next  = tsh_reg[31]; // RL6
        oe_next  = 1'b1;
        tsh_next = tsh_reg << 1;
        st_next  = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (srg.fall_p) begin
          sck_next = 1'b0;
          if (!is_b) begin
            dx_next  = tsh_reg[31]; // RL1
            oe_next  = 1'b1;
            tsh_next = tsh_reg << 1;
          end
        end
        if (srg.rise_p) begin
          sck_next = 1'b1;
          rsh_next = {rsh_reg[30:0], sy_rx}; // RL3
          cnt_next = cnt_reg + 6'd1;
          if (last) begin
            rxd_next = {rsh_reg[30:0], sy_rx};
            st_next  = ST_TAIL; // RL16
            if (is_b) oe_next = 1'b0; // RL4
          end else if (is_b) begin
            dx_next  = tsh_reg[31]; // RL2
            tsh_next = tsh_reg << 1;
          end
        end
      end
      ST_TAIL: begin
        if (srg.fall_p) begin
          if (!is_b) begin
            oe_next = 1'b0; // RL4
          end else begin
            sel_next = 1'b0; // RL2
            dp_next  = 1'b1;
            st_next  = ST_IDLE;
          end
        end
        if (srg.rise_p && !is_b) begin
          sel_next = 1'b0; // RL1
          dp_next  = 1'b1;
          st_next  = ST_IDLE;
        end
      end
      ST_SLAVE: begin
        if (!s_act) begin
          oe_next  = 1'b0; // RL5
          rxd_next = rsh_reg;
          dp_next  = 1'b1;
          st_next  = ST_IDLE;
        end else begin
          if (s_rise) begin
            rsh_next = {rsh_reg[30:0], sy_rx}; // RL3
            cnt_next = cnt_reg + 6'd1;
            if (is_b && !last) begin
              dx_next  = tsh_reg[31];
              tsh_next = tsh_reg << 1;
            end
          end
          if (s_fall && !is_b && cnt_reg != 6'd0 && cnt_reg < bits) begin
            dx_next  = tsh_reg[31];
            tsh_next = tsh_reg << 1;
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase
    run_next = (st_next == ST_LEAD) || (st_next == ST_SHIFT) || (st_next == ST_TAIL);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg  <= ST_IDLE; tsh_reg <= 32'h00000000; rsh_reg <= 32'h00000000;
      rxd_reg <= 32'h00000000; cnt_reg <= 6'd0; sck_reg <= 1'b1; sel_reg <= 1'b0;
      dx_reg  <= 1'b0; oe_reg <= 1'b0; run_reg <= 1'b0; dp_reg <= 1'b0;
      ck_q_reg <= 1'b1; sl_q_reg <= 1'b1; ex_q_reg <= 1'b1; tk_reg <= 1'b0;
      tx_select_pin_o <= 1'b1;
    end else begin
      st_reg  <= st_next; tsh_reg <= tsh_next; rsh_reg <= rsh_next;
      rxd_reg <= rxd_next; cnt_reg <= cnt_next; sck_reg <= sck_next; sel_reg <= sel_next;
      dx_reg  <= dx_next; oe_reg <= oe_next; run_reg <= run_next; dp_reg <= dp_next;
      ck_q_reg <= sy_clk; sl_q_reg <= s_act; ex_q_reg <= sy_ext;
      tk_reg   <= sy_ext & ~ex_q_reg;
      tx_select_pin_o <= sel_next ^ ctrl_reg[CB_TXSLPOL]; // RL13
    end
  end

  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = wr_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign tx_serial_clock_pin_o  = sck_reg;
  assign tx_serial_clock_pin_oe = ctrl_reg[CB_TXCKDIR];
  assign tx_select_pin_oe       = ctrl_reg[CB_TXSLDIR];
  assign tx_data_pin_o          = dx_reg;
  assign tx_data_pin_oe         = oe_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [9:0] per_reg;
  logic       seen_reg;
  always_ff @(posedge mclk) begin
    if (rst || !run_reg) begin
      per_reg  <= 10'd0;
      seen_reg <= 1'b0;
    end else begin
      per_reg  <= srg.rise_p ? 10'd1 : per_reg + 10'd1;
      seen_reg <= seen_reg | srg.rise_p;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_lead_rise;
    st_reg == ST_LEAD && srg.rise_p;
  endsequence
  sequence s_tail_end_b;
    st_reg == ST_TAIL && is_b && srg.fall_p;
  endsequence

  a_clk_period: assert property ((srg.rise_p && seen_reg && ctrl_reg[CB_SRC] && div_reg != 8'h00
    && $stable(div_reg)) |-> per_reg == 10'(CPU_DIV * (div_reg + 1))) // RL7
    else $error("Bit clock period wrong");
  // The fall ends the high phase, so the count holds the high width here
  a_high_phase: assert property ((srg.fall_p && seen_reg && ctrl_reg[CB_SRC] && div_reg != 8'h00)
    |-> per_reg == (div_reg[0] ? 10'(div_reg) + 10'd1 : 10'(div_reg) + 10'd2)) // RL8
    else $error("Bit clock high phase wrong");
  a_launch_fall: assert property ((st_reg == ST_SHIFT && !is_b && srg.fall_p)
    |=> !tx_serial_clock_pin_o && tx_data_pin_oe) // RL1
    else $error("Launch not on falling edge");
  a_lead_data: assert property (s_lead_rise |=> tx_data_pin_oe && tx_serial_clock_pin_o) // RL6
    else $error("Lead bit not presented");
  a_end_b: assert property (s_tail_end_b |=> st_reg == ST_IDLE && !tx_data_pin_oe) // RL2
    else $error("Variant 11 tail wrong");
  a_sample_rise: assert property ((st_reg == ST_SHIFT && srg.rise_p)
    |=> rsh_reg[0] == $past(sy_rx) && cnt_reg == $past(cnt_reg) + 6'd1) // RL3
    else $error("Receive not sampled on rise");
  a_release_b: assert property ((st_reg == ST_SHIFT && is_b && srg.rise_p && last)
    |=> !tx_data_pin_oe) // RL4
    else $error("Data not released at last rise");
  a_slave_off: assert property ((st_reg == ST_SLAVE && !s_act) |=> !tx_data_pin_oe ##1 !tx_data_pin_oe) // RL5
    else $error("Slave data not released");
  a_slave_on: assert property ((st_reg == ST_IDLE && slv && s_act) |=> tx_data_pin_oe) // RL6
    else $error("Slave first bit late");
  a_sel_low: assert property ((st_reg == ST_SHIFT && ctrl_reg[CB_TXSLPOL]) |-> !tx_select_pin_o) // RL13
    else $error("Select pin not active low");
  a_bit_count: assert property (cnt_reg <= bits) // RL16
    else $error("Bit count overrun");
endmodule

//--- scs_pkg.sv
// Purpose: Shared constants and types for the clock-stop serial port
// Assumes: 25 MHz mclk, AXI4-Lite register access
// Notes:   Offsets are byte addresses
package scs_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_DIV    = 8'h04;
  localparam logic [7:0] OFF_WLEN   = 8'h08;
  localparam logic [7:0] OFF_TXDATA = 8'h0C;
  localparam logic [7:0] OFF_RXDATA = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CB_START   = 0;
  localparam int CB_VAR     = 1;
  localparam int CB_CLKPOL  = 3;
  localparam int CB_SRC     = 4;
  localparam int CB_TXCKDIR = 5;
  localparam int CB_RXCKDIR = 6;
  localparam int CB_TXSLDIR = 7;
  localparam int CB_RXSLDIR = 8;
  localparam int CB_TXSLPOL = 9;
  localparam int CB_RXSLPOL = 10;
  localparam int SB_BUSY    = 0;
  localparam int SB_DONE    = 1;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [31:0] RST_CTRL = 32'h0000061C;
  localparam logic [7:0]  RST_DIV  = 8'h01;
  localparam logic [4:0]  RST_WLEN = 5'h07;
  localparam logic [1:0]  VAR_A    = 2'h2;
  localparam logic [1:0]  VAR_B    = 2'h3;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  localparam int          MCLK_NS  = 40;
  localparam int          CPU_DIV  = 2;
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL, ST_SLAVE} scs_state_e;
endpackage

//--- scs_srg_if.sv
// Purpose: Link between the engine and the bit clock generator
// Assumes: Single mclk domain
// Notes:   ctl drives the generator, gen answers with phase pulses
interface scs_srg_if;
  logic       run;
  logic       start_low;
  logic       src_sel;
  logic       ext_tick;
  logic [7:0] div;
  logic       lvl;
  logic       rise_p;
  logic       fall_p;
  modport ctl (output run, start_low, src_sel, ext_tick, div, input lvl, rise_p, fall_p);
  modport gen (input run, start_low, src_sel, ext_tick, div, output lvl, rise_p, fall_p);
endinterface

//--- scs_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage is read only by the second
module scs_sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (rst) begin
        s1_reg[i] <= 1'b1;
        q[i]      <= 1'b1;
      end else begin
        s1_reg[i] <= d[i];
        q[i]      <= s1_reg[i];
      end
    end
  end
endmodule

//--- scs_bit_clock_gen.sv
// Purpose: Sample-rate divider producing the bit clock phases
// Assumes: ext_tick is a one-cycle pulse per external clock rising edge
// Notes:   A zero divider is stretched to one tick per phase
module scs_bit_clock_gen
  import scs_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  scs_srg_if.gen    srg
);
  logic       tog_reg, tog_next;
  logic [8:0] cnt_reg, cnt_next;
  logic       ph_reg, ph_next;
  logic       rise_reg, rise_next;
  logic       fall_reg, fall_next;
  logic [8:0] half, hi_len, lo_len;
  logic       tick;

  assign tick = srg.src_sel ? tog_reg : srg.ext_tick; // RL9
  assign half = ({1'b0, srg.div} + 9'd1) >> 1;

  always_comb begin
    hi_len    = (srg.div == 8'h00) ? 9'd1 : (srg.div[0] ? half : {2'b00, srg.div[7:1]} + 9'd1); // RL8
    lo_len    = (srg.div == 8'h00) ? 9'd1 : (srg.div[0] ? half : {2'b00, srg.div[7:1]}); // RL8
    tog_next  = ~tog_reg;
    cnt_next  = cnt_reg;
    ph_next   = ph_reg;
    rise_next = 1'b0;
    fall_next = 1'b0;
    if (!srg.run) begin
      cnt_next = 9'd0;
      ph_next  = ~srg.start_low;
    end else if (tick) begin
      // Period is hi_len + lo_len = divider + 1 ticks, or 2 ticks for a zero divider
      if (cnt_reg + 9'd1 >= (ph_reg ? hi_len : lo_len)) begin // RL7
        cnt_next  = 9'd0;
        ph_next   = ~ph_reg;
        rise_next = ~ph_reg;
        fall_next = ph_reg;
      end else begin
        cnt_next = cnt_reg + 9'd1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tog_reg  <= 1'b0;
      cnt_reg  <= 9'd0;
      ph_reg   <= 1'b1;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      tog_reg  <= tog_next;
      cnt_reg  <= cnt_next;
      ph_reg   <= ph_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign srg.lvl    = ph_reg;
  assign srg.rise_p = rise_reg;
  assign srg.fall_p = fall_reg;
endmodule

//--- scs_slave_model.sv
// Purpose: Far-side serial peripheral for the port acting as bus master
// Assumes: Clock idles high, select active low, word length given by wlen
// Notes:   Released data line shows the inverse of its last bit
module scs_slave_model #(
  parameter logic [31:0] PAT = 32'hC3A5_9E17
) (
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic [4:0]  wlen,
  input  wire logic        vb,
  output logic             miso,
  output logic      [31:0] got,
  output int               nbits
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  bit seen_rise;
  initial begin
    miso = 1'b0;
    got = 32'h0;
    nbits = 0;
  end
  always @(negedge sel_n) begin
    cnt = wlen;
    seen_rise = 0;
    nbits = 0;
    miso = PAT[cnt];
  end
  // Variant 10b data moves on falls, so take it on rises; 11b moves on rises,
  // so take it on falls to stay clear of the launching edge
  always @(posedge sck) if (!sel_n) begin
    if (!vb) begin
      got = {got[30:0], mosi};
      nbits++;
    end
    seen_rise = 1;
  end
  always @(negedge sck) if (!sel_n && vb) begin
    got = {got[30:0], mosi};
    nbits++;
  end
  // Shift out on falls after the first rise so the first bit stays up
  always @(negedge sck) if (!sel_n && seen_rise && cnt > 0) begin
    cnt--;
    miso = PAT[cnt];
  end
  always @(posedge sel_n) miso = ~miso;
endmodule

//--- scs_spi_port_tb.sv
// Purpose: Self-checking bench for the clock-stop serial port in master role
// Assumes: 25 MHz mclk, divider fed from CPU clock over two
// Notes:   Edge times are measured on the pin levels in ns
module scs_spi_port_tb;
  import scs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [1:0] rs;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, got;
  logic sck_o, sck_oe, sel_o, sel_oe, dat_o, dat_oe, miso, sck, seln;
  logic [4:0] wl_m = 5'h07;
  logic vb_m = 0;
  int errors = 0, compares = 0, nbits;
  time t_sel, t_e, lead, hi_w, lo_w, tail;
  bit first;
  localparam logic [31:0] PAT = 32'hC3A5_9E17;
  always #20 mclk = ~mclk;
  // Wire levels seen by both parties; pull-ups keep idle lines high
  assign sck = sck_oe ? sck_o : 1'b1;
  assign seln = sel_oe ? sel_o : 1'b1;
  scs_spi_port DUT (.mclk(mclk), .rst(rst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .ext_clock_pin(1'b0),
    .tx_serial_clock_pin_i(sck), .tx_serial_clock_pin_o(sck_o), .tx_serial_clock_pin_oe(sck_oe),
    .tx_select_pin_i(seln), .tx_select_pin_o(sel_o), .tx_select_pin_oe(sel_oe),
    .rx_select_pin_i(1'b1), .rx_data_pin(miso), .tx_data_pin_o(dat_o), .tx_data_pin_oe(dat_oe));
  scs_slave_model #(.PAT(PAT)) u_peer (.sck(sck), .sel_n(seln), .mosi(dat_o), .wlen(wl_m), .vb(vb_m),
    .miso(miso), .got(got), .nbits(nbits));
  // ----------------------------------------
  // Pin timing monitor
  // ----------------------------------------
  always @(negedge seln) begin
    t_sel = $time;
    first = 1;
  end
  always @(negedge sck) if (!seln) begin
    if (first) lead = $time - t_sel;
    else hi_w = $time - t_e;
    first = 0;
    t_e = $time;
  end
  always @(posedge sck) if (!seln) begin
    lo_w = $time - t_e;
    t_e = $time;
  end
  always @(posedge seln) tail = $time - t_e;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1 && n < 100);
    bready <= 0;
    chk("bresp", {30'h0, bresp}, {30'h0, RESP_OK});
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1 && n < 100);
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask
  function automatic bit near(time v, time e);
    return v + MCLK_NS >= e && v <= e + MCLK_NS;
  endfunction
  task automatic xfer(input logic [1:0] vr, input int dv, input logic [4:0] wl,
                      input logic [31:0] tx);
    time s, hi, lo, t;
    logic [31:0] m;
    int n;
    s = CPU_DIV * MCLK_NS;
    hi = (dv % 2 == 0) ? (dv / 2 + 1) * s : (dv + 1) / 2 * s;
    lo = (dv % 2 == 0) ? dv / 2 * s : (dv + 1) / 2 * s;
    t = (1 + dv) * s;
    m = (64'h1 << (wl + 1)) - 1;
    wl_m = wl;
    vb_m = (vr == VAR_B);
    n = 0;
    wr(OFF_DIV, dv);
    wr(OFF_WLEN, {27'h0, wl});
    wr(OFF_TXDATA, tx);
    wr(OFF_CTRL, 32'h6B9 | {29'h0, vr, 1'b0});
    do begin
      rdr(OFF_STATUS);
      n++;
    end while (rd[SB_DONE] !== 1'b1 && n < 300);
    chk("hi_w", hi_w, hi);
    chk("lo_w", lo_w, lo);
    chk("period", hi_w + lo_w, t);
    chk("lead", near(lead, vr == VAR_B ? t : hi), 1);
    chk("tail", near(tail, vr == VAR_B ? hi : t), 1);
    chk("mosi", got & m, tx & m);
    chk("nbits", nbits, wl + 1);
    chk("data_oe", dat_oe, 0);
    chk("sel_pin", sel_o, 1);
    rdr(OFF_RXDATA);
    // Receive data passes two sync flops, so the low phase must cover that delay
    if (lo >= 4 * MCLK_NS) chk("rxdata", rd & m, PAT & m);
    wr(OFF_STATUS, 32'h2);
    $display("test transfer variant %0d divider %0d done", vr, dv);
  endtask
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #400000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 0;
    rdr(OFF_CTRL);
    chk("ctrl", rd, RST_CTRL);
    rdr(OFF_DIV);
    chk("div", rd, {24'h0, RST_DIV});
    rdr(OFF_WLEN);
    chk("wlen", rd, {27'h0, RST_WLEN});
    rdr(8'h18);
    chk("unmapped", {30'h0, rs}, {30'h0, RESP_ERR});
    chk("idle_clk", sck_o, 1);
    chk("idle_oe", dat_oe, 0);
    $display("test reset values done");
    xfer(VAR_A, 3, 5'h07, 32'h0000_00A5);
    xfer(VAR_B, 2, 5'h0F, 32'h0000_3C5A);
    xfer(VAR_A, 4, 5'h1F, 32'h8E31_F00D);
    wrap_up();
  end
endmodule
